// [rtl/parp_params.svh]
/*
 * constants for the paged address relocation and protection block:
 * field positions, widths, reset values and the abort vector.
 * assumes: included by bare name from the rtl files only.
 */
`ifndef PARP_PARAMS_SVH
`define PARP_PARAMS_SVH

// virtual address fields
`define PARP_APS_HI      15
`define PARP_APS_LO      13
`define PARP_BLK_HI      12
`define PARP_BLK_LO      6
`define PARP_OFS_HI      12
// page base field counts 64-byte blocks
`define PARP_BASE_SHIFT  6
`define PARP_BASE_W      12
`define PARP_PA_W        18
`define PARP_LEN_W       7
`define PARP_KEY_W       3
// reset values and the abort vector
`define PARP_BASE_RST    12'h000
`define PARP_LEN_RST     7'h00
`define PARP_KEY_RST     3'h0
`define PARP_ABORT_VEC   16'h00A8

`endif

// [rtl/parp_pkg.sv]
/*
 * types shared by the relocation block.
 * assumes: parp_params.svh is reachable on the include path.
 */
package parp_pkg;
    typedef enum logic [1:0] {
        PARP_KERNEL = 2'b00,
        PARP_SUPER  = 2'b01,
        PARP_ILLEGAL = 2'b10,
        PARP_USER   = 2'b11
    } parp_mode_t;

    typedef enum logic [2:0] {
        PARP_K_NR0  = 3'b000,
        PARP_K_ROT  = 3'b001,
        PARP_K_RO   = 3'b010,
        PARP_K_NR3  = 3'b011,
        PARP_K_RWT  = 3'b100,
        PARP_K_RWWT = 3'b101,
        PARP_K_RW   = 3'b110,
        PARP_K_NR7  = 3'b111
    } parp_key_t;
endpackage

// [rtl/parp_check.sv]
/*
 * combinational protection check of one reference against a descriptor.
 * assumes: outputs are registered by the caller; no state here.
 */
`timescale 1ns/1ns
`include "parp_params.svh"
module parp_check
    import parp_pkg::*;
(
    input  wire logic [`PARP_LEN_W-1:0] blk,
    input  wire logic [`PARP_LEN_W-1:0] len,
    input  wire logic                   dir_down,
    input  wire logic [`PARP_KEY_W-1:0] key,
    input  wire logic                   is_write,
    output logic                        nonres,
    output logic                        len_err,
    output logic                        ro_err,
    output logic                        trap
);
    parp_key_t k;
    always_comb begin
        k = parp_key_t'(key);
        nonres = (k == PARP_K_NR0) || (k == PARP_K_NR3)
              || (k == PARP_K_NR7);
        // direction bit: 0 grows up, 1 grows down
        if (dir_down) begin
            len_err = (blk < len);
        end else begin
            len_err = (blk > len);
        end
        ro_err = is_write
              && ((k == PARP_K_ROT) || (k == PARP_K_RO));
        trap = is_write ? ((k == PARP_K_RWT) || (k == PARP_K_RWWT))
                        : ((k == PARP_K_ROT) || (k == PARP_K_RWT));
    end
endmodule // parp_check

// [rtl/parp_mmu.sv]
/*
 * paged relocation: maps a 16-bit virtual address to an 18-bit physical
 * address through per-mode, per-space page tables, checks length, keys,
 * and keeps accessed and written flags.
 * assumes: the core holds req for one cycle per reference and reads the
 * answer on the following cycle; table writes come from supervisory code
 * through the plain load port.
 */
`timescale 1ns/1ns
`include "parp_params.svh"
module parp_mmu
    import parp_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // relocation on; when off, addresses pass unchanged
    input  wire logic                    reloc_en,
    // per-mode data space enable: bit0 user, bit1 super, bit2 kernel
    input  wire logic [2:0]              dspace_en,
    // reference request from the core
    input  wire logic                    req,
    input  wire logic [15:0]             va,
    input  wire logic [1:0]              mode,
    input  wire logic                    dspace,
    input  wire logic                    is_write,
    // table load port
    input  wire logic                    ld_we,
    input  wire logic [1:0]              ld_mode,
    input  wire logic                    ld_dspace,
    input  wire logic [2:0]              ld_page,
    input  wire logic                    ld_base,
    input  wire logic                    ld_desc,
    input  wire logic [`PARP_BASE_W-1:0] ld_base_val,
    input  wire logic [`PARP_LEN_W-1:0]  ld_len,
    input  wire logic                    ld_dir,
    input  wire logic [`PARP_KEY_W-1:0]  ld_key,
    // table read-back
    input  wire logic [1:0]              rd_mode,
    input  wire logic                    rd_dspace,
    input  wire logic [2:0]              rd_page,
    output logic [`PARP_BASE_W-1:0]      rd_base,
    output logic [`PARP_LEN_W-1:0]       rd_len,
    output logic                         rd_dir,
    output logic [`PARP_KEY_W-1:0]       rd_key,
    output logic                         rd_accessed,
    output logic                         rd_written,
    // answer, one cycle after req
    output logic                         ack,
    output logic [`PARP_PA_W-1:0]        pa,
    output logic                         mem_we,
    output logic                         abort,
    output logic                         abort_nonres,
    output logic                         abort_len,
    output logic                         abort_ro,
    output logic                         mm_trap,
    output logic [15:0]                  vector
);
    // ****************************************************************
    // page tables: 4 mode codes x 2 spaces x 8 pages, index {mode,space,page}
    // ****************************************************************
    localparam int NENT = 64;
    // flat arrays: the flags of any entry may change on any cycle

    logic [`PARP_BASE_W-1:0] base_q [NENT];
    logic [`PARP_LEN_W-1:0]  len_q  [NENT];
    logic                    dir_q  [NENT];
    logic [`PARP_KEY_W-1:0]  key_q  [NENT];
    logic                    acc_q  [NENT];
    logic                    wr_q   [NENT];

    logic [NENT-1:0] acc_set;
    logic [NENT-1:0] wr_set;

    // ****************************************************************
    // lookup
    // ****************************************************************
    logic                    use_d;
    logic [5:0]              idx;
    logic [2:0]              aps;
    logic [`PARP_LEN_W-1:0]  blk;
    logic [`PARP_BASE_W-1:0] cur_base;
    logic [`PARP_LEN_W-1:0]  cur_len;
    logic                    cur_dir;
    logic [`PARP_KEY_W-1:0]  cur_key;
    logic                    nonres;
    logic                    len_err;
    logic                    ro_err;
    logic                    trap_kind;
    logic                    mode_bad;
    logic                    any_abort;
    logic [`PARP_PA_W-1:0]   base_bytes;
    logic [`PARP_PA_W-1:0]   offset;
    logic [`PARP_PA_W-1:0]   phys;

    always_comb begin
        // page and block index are plain slices of the virtual address
        aps = va[`PARP_APS_HI:`PARP_APS_LO];
        blk = va[`PARP_BLK_HI:`PARP_BLK_LO];
        // mode 10 selects no space of its own; it aborts further down
        unique case (parp_mode_t'(mode))
            PARP_USER:    use_d = dspace & dspace_en[0];
            PARP_SUPER:   use_d = dspace & dspace_en[1];
            PARP_KERNEL:  use_d = dspace & dspace_en[2];
            PARP_ILLEGAL: use_d = 1'b0;
        endcase
        idx      = {mode, use_d, aps};
        cur_base = base_q[idx];
        cur_len  = len_q[idx];
        cur_dir  = dir_q[idx];
        cur_key  = key_q[idx];
    end

    parp_check u_check (
        .blk      (blk),
        .len      (cur_len),
        .dir_down (cur_dir),
        .key      (cur_key),
        .is_write (is_write),
        .nonres   (nonres),
        .len_err  (len_err),
        .ro_err   (ro_err),
        .trap     (trap_kind)
    );

    always_comb begin
        mode_bad  = (parp_mode_t'(mode) == PARP_ILLEGAL);
        any_abort = nonres | len_err | ro_err | mode_bad;
        // base is free-form: pages may overlap or run backwards
        base_bytes = {6'h00, cur_base} << `PARP_BASE_SHIFT;
        offset     = {5'h00, va[`PARP_OFS_HI:0]};
        phys       = base_bytes + offset;
        acc_set = '0;
        wr_set  = '0;
        if (req && reloc_en && !mode_bad) begin
            acc_set[idx] = any_abort | trap_kind;
            wr_set[idx]  = is_write & ~any_abort;
        end
    end

    // ****************************************************************
    // table next state
    // ****************************************************************
    logic [5:0]              ld_idx;
    logic [`PARP_BASE_W-1:0] base_d [NENT];
    logic [`PARP_LEN_W-1:0]  len_d  [NENT];
    logic                    dir_d  [NENT];
    logic [`PARP_KEY_W-1:0]  key_d  [NENT];
    logic                    acc_d  [NENT];
    logic                    wr_d   [NENT];

    assign ld_idx = {ld_mode, ld_dspace, ld_page};

    // base and descriptor halves load separately, as software writes them
    always_comb begin
        for (int i = 0; i < NENT; i++) begin
            base_d[i] = base_q[i];
            len_d[i]  = len_q[i];
            dir_d[i]  = dir_q[i];
            key_d[i]  = key_q[i];
            // flags only accumulate; software clears them by a reload
            acc_d[i]  = acc_q[i] | acc_set[i];
            wr_d[i]   = wr_q[i] | wr_set[i];
            if (ld_we && ld_base && ld_idx == 6'(i)) begin
                base_d[i] = ld_base_val;
            end
            // a descriptor load clears the flags unless hardware
            // sets one the same cycle: the set wins
            if (ld_we && ld_desc && ld_idx == 6'(i)) begin
                len_d[i] = ld_len;
                dir_d[i] = ld_dir;
                key_d[i] = ld_key;
                acc_d[i] = acc_set[i];
                wr_d[i]  = wr_set[i];
            end
        end
    end

    // ****************************************************************
    // table state
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NENT; i++) begin
                base_q[i] <= `PARP_BASE_RST;
                len_q[i]  <= `PARP_LEN_RST;
                dir_q[i]  <= 1'b0;
                key_q[i]  <= `PARP_KEY_RST;
                acc_q[i]  <= 1'b0;
                wr_q[i]   <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NENT; i++) begin
                base_q[i] <= base_d[i];
                len_q[i]  <= len_d[i];
                dir_q[i]  <= dir_d[i];
                key_q[i]  <= key_d[i];
                acc_q[i]  <= acc_d[i];
                wr_q[i]   <= wr_d[i];
            end
        end
    end

    // ****************************************************************
    // answer registers
    // ****************************************************************
    logic                    ack_d;
    logic [`PARP_PA_W-1:0]   pa_d;
    logic                    we_d;
    logic                    ab_d;
    logic                    abn_d;
    logic                    abl_d;
    logic                    abr_d;
    logic                    trap_d;
    logic [15:0]             vec_d;
    logic [5:0]              rd_idx;

    always_comb begin
        // relocation off: flat pass-through, no checks and no flags
        ack_d  = req;
        pa_d   = {2'b00, va};
        we_d   = req & is_write;
        ab_d   = 1'b0;
        abn_d  = 1'b0;
        abl_d  = 1'b0;
        abr_d  = 1'b0;
        trap_d = 1'b0;
        vec_d  = 16'h0000;
        if (req && reloc_en) begin
            pa_d  = phys;
            abn_d = nonres | mode_bad;
            abl_d = len_err & ~mode_bad;
            abr_d = ro_err & ~mode_bad;
            ab_d  = abn_d | abl_d | abr_d;
            // aborted write never reaches memory
            we_d  = is_write & ~ab_d;
            // trap rides with the completed access, not before it
            trap_d = trap_kind & ~ab_d;
            if (ab_d) begin
                vec_d = `PARP_ABORT_VEC;
            end
        end
        // read-back lags its select by one cycle, like the answer
        rd_idx = {rd_mode, rd_dspace, rd_page};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack          <= 1'b0;
            pa           <= '0;
            mem_we       <= 1'b0;
            abort        <= 1'b0;
            abort_nonres <= 1'b0;
            abort_len    <= 1'b0;
            abort_ro     <= 1'b0;
            mm_trap      <= 1'b0;
            vector       <= 16'h0000;
            rd_base      <= `PARP_BASE_RST;
            rd_len       <= `PARP_LEN_RST;
            rd_dir       <= 1'b0;
            rd_key       <= `PARP_KEY_RST;
            rd_accessed  <= 1'b0;
            rd_written   <= 1'b0;
        end else begin
            ack          <= ack_d;
            pa           <= pa_d;
            mem_we       <= we_d;
            abort        <= ab_d;
            abort_nonres <= abn_d;
            abort_len    <= abl_d;
            abort_ro     <= abr_d;
            mm_trap      <= trap_d;
            vector       <= vec_d;
            rd_base      <= base_q[rd_idx];
            rd_len       <= len_q[rd_idx];
            rd_dir       <= dir_q[rd_idx];
            rd_key       <= key_q[rd_idx];
            rd_accessed  <= acc_q[rd_idx];
            rd_written   <= wr_q[rd_idx];
        end
    end
endmodule // parp_mmu

// [verif/parp_mmu_checker.sv]
/*
 * timing and flag checks on the answer side of the relocation block.
 * assumes: bound to parp_mmu; one clock, async active-high reset.
 */
`timescale 1ns/1ns
module parp_mmu_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        reloc_en,
    input wire logic        req,
    input wire logic        is_write,
    input wire logic [15:0] va,
    input wire logic        ack,
    input wire logic [17:0] pa,
    input wire logic        mem_we,
    input wire logic        abort,
    input wire logic        abort_nonres,
    input wire logic        abort_len,
    input wire logic        abort_ro,
    input wire logic        mm_trap,
    input wire logic [15:0] vector
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_ack; req |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_only; ack |-> $past(req); endproperty
    a_only: assert property (p_only) else $error("stray answer");
    property p_thru;
        req && !reloc_en |=> pa == {2'b00, $past(va)} && !abort;
    endproperty
    a_thru: assert property (p_thru) else $error("bad bypass");
    property p_vec; abort |-> vector == 16'h00A8; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_vec0; ack && !abort |-> vector == 16'h0000; endproperty
    a_vec0: assert property (p_vec0) else $error("vector set");
    property p_cause;
        abort |-> ack && (abort_nonres || abort_len || abort_ro);
    endproperty
    a_cause: assert property (p_cause) else $error("no cause");
    property p_ro; abort_ro |-> abort && !mem_we && $past(is_write);
    endproperty
    a_ro: assert property (p_ro) else $error("bad ro abort");
    property p_we; mem_we |-> ack && !abort && $past(is_write); endproperty
    a_we: assert property (p_we) else $error("bad write");
    property p_trap; mm_trap |-> ack && !abort; endproperty
    a_trap: assert property (p_trap) else $error("bad trap");
    c_len: cover property (abort_len);
    c_trap: cover property (mm_trap);
    c_we: cover property (mem_we);
    c_ro: cover property (abort_ro);
endmodule // parp_mmu_checker

bind parp_mmu parp_mmu_checker u_chk (.ref_clk, .rst, .reloc_en, .req,
    .is_write, .va, .ack, .pa, .mem_we, .abort, .abort_nonres, .abort_len,
    .abort_ro, .mm_trap, .vector);

// [verif/parp_core.sv]
/*
 * core-side model: issues one reference per call of issue.
 * assumes: the caller reads the answer when issue returns.
 */
`timescale 1ns/1ns
module parp_core (
    input  wire logic  ref_clk,
    output logic       req,
    output logic [15:0] va,
    output logic [1:0] mode,
    output logic       dspace,
    output logic       is_write
);
    initial begin
        {req, va, mode, dspace, is_write} = '0;
    end
    task automatic issue(input logic [15:0] a, input logic [1:0] m,
                         input logic d, input logic w);
        @(posedge ref_clk);
        {req, va, mode, dspace, is_write} <= {1'b1, a, m, d, w};
        @(posedge ref_clk);
        // address and write flip once taken so a stale value cannot pass
        {req, va, is_write} <= {1'b0, ~a, ~w};
        #1;
    endtask
endmodule // parp_core

// [verif/tb.sv]
/*
 * self-checking bench for the relocation block.
 * assumes: parp_core drives the reference side; bench loads tables.
 */
`timescale 1ns/1ns
module tb;
    logic ref_clk, rst, reloc_en, req, dspace, is_write, ld_we, ld_dspace;
    logic ld_base, ld_desc, ld_dir, rd_dspace, rd_dir, rd_accessed;
    logic rd_written, ack, mem_we, abort, abort_nonres, abort_len;
    logic abort_ro, mm_trap;
    logic [2:0]  dspace_en, ld_page, ld_key, rd_page, rd_key;
    logic [1:0]  mode, ld_mode, rd_mode;
    logic [15:0] va, vector;
    logic [11:0] ld_base_val, rd_base;
    logic [6:0]  ld_len, rd_len;
    logic [17:0] pa;
    int          fails = 0;
    int          total_checks = 0;

    parp_core core (.ref_clk, .req, .va, .mode, .dspace, .is_write);
    parp_mmu uut (.ref_clk, .rst, .reloc_en, .dspace_en, .req, .va, .mode,
        .dspace, .is_write, .ld_we, .ld_mode, .ld_dspace, .ld_page, .ld_base,
        .ld_desc, .ld_base_val, .ld_len, .ld_dir, .ld_key, .rd_mode,
        .rd_dspace, .rd_page, .rd_base, .rd_len, .rd_dir, .rd_key,
        .rd_accessed, .rd_written, .ack, .pa, .mem_we, .abort, .abort_nonres,
        .abort_len, .abort_ro, .mm_trap, .vector);

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic stop_test;
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic ck(input string n, input logic [17:0] e, g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic load(input logic [2:0] c, p, input logic [11:0] b,
                        input logic [6:0] l, input logic dr, input logic [2:0] k);
        @(posedge ref_clk);
        {ld_we, ld_mode, ld_dspace, ld_page} <= {1'b1, c[2:1], c[0], p};
        {ld_base_val, ld_len, ld_dir, ld_key} <= {b, l, dr, k};
        @(posedge ref_clk);
        {ld_we, ld_base_val} <= {1'b0, ~b};
    endtask
    task automatic rdb(input logic [2:0] c, input logic [2:0] p);
        @(posedge ref_clk);
        {rd_mode, rd_dspace, rd_page} <= {c[2:1], c[0], p};
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    // c holds mode, space and write; flags: abort,nonres,len,ro,trap,we
    task automatic rc(input logic [15:0] a, input logic [3:0] c,
                      input logic [17:0] ep, input logic [5:0] ef);
        core.issue(a, c[3:2], c[1], c[0]);
        ck("ack", 18'h00001, {17'h00000, ack});
        ck("flags", {12'h000, ef}, {12'h000, abort, abort_nonres,
           abort_len, abort_ro, mm_trap, mem_we});
        if (!ef[5]) ck("pa", ep, pa);
        ck("vector", ef[5] ? 18'h000A8 : 18'h00000, {2'b00, vector});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_walk;
        load(3'h0, 3'h6, 12'h0CA, 7'h28, 1'b0, 3'h1);
        rc(16'hCA00, 4'h0, 18'h03C80, 6'h02);
        rc(16'hCA40, 4'h0, 18'h00000, 6'h28);
        rc(16'hC000, 4'h1, 18'h00000, 6'h24);
        rdb(3'h0, 3'h6);
        ck("base", 18'h000CA, {6'h00, rd_base});
        ck("desc", 18'h00281, {7'h00, rd_len, rd_dir, rd_key});
        ck("acc wr", 18'h00002, {16'h0000, rd_accessed, rd_written});
    endtask
    task automatic t_down;
        load(3'h0, 3'h0, 12'h100, 7'h7D, 1'b1, 3'h6);
        rc(16'h1F00, 4'h0, 18'h00000, 6'h28);
        rc(16'h1F40, 4'h1, 18'h05F40, 6'h01);
        rc(16'h1FC0, 4'h0, 18'h05FC0, 6'h00);
        rdb(3'h0, 3'h0);
        ck("acc wr", 18'h00003, {16'h0000, rd_accessed, rd_written});
    endtask
    task automatic t_keys;
        logic nr, ro, tr, acc;
        for (int k = 0; k < 8; k++) begin
            load(3'h0, 3'h0, 12'h000, 7'h7F, 1'b0, 3'(k));
            nr = (k == 0) || (k == 3) || (k == 7);
            tr = !nr && (k == 1 || k == 4);
            acc = nr || tr;
            rc(16'h0040, 4'h0, 18'h00040, {nr, nr, 2'b00, tr, 1'b0});
            ro = !nr && (k == 1 || k == 2);
            tr = !nr && !ro && (k == 4 || k == 5);
            acc = acc || nr || ro || tr;
            rc(16'h0040, 4'h1, 18'h00040,
               {nr || ro, nr, 1'b0, ro, tr, !(nr || ro)});
            rdb(3'h0, 3'h0);
            ck("acc wr", {16'h0000, acc, !(nr || ro)},
               {16'h0000, rd_accessed, rd_written});
            ck("key", 18'(k), {15'h0000, rd_key});
        end
    endtask
    task automatic t_space;
        load(3'h7, 3'h2, 12'h010, 7'h7F, 1'b0, 3'h6);
        load(3'h6, 3'h2, 12'h020, 7'h7F, 1'b0, 3'h6);
        load(3'h2, 3'h2, 12'h030, 7'h7F, 1'b0, 3'h6);
        dspace_en <= 3'b001;
        rc(16'h4044, 4'hE, 18'h00444, 6'h00);
        rc(16'h4044, 4'hC, 18'h00844, 6'h00);
        dspace_en <= 3'b100;
        rc(16'h4044, 4'hE, 18'h00844, 6'h00);
        rc(16'h4044, 4'h4, 18'h00C44, 6'h00);
        rc(16'h4044, 4'h6, 18'h00C44, 6'h00);
        rc(16'h4004, 4'hA, 18'h00000, 6'h30);
        reloc_en <= 1'b0;
        rc(16'hF044, 4'hB, 18'h0F044, 6'h01);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        fails++;
        stop_test;
    end
    initial begin
        {rst, reloc_en, dspace_en, ld_base, ld_desc} = 7'h73;
        {ld_we, ld_mode, ld_dspace, ld_base_val, ld_len, ld_dir} = '0;
        {ld_key, rd_mode, rd_dspace, rd_page} = '0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rdb(3'h0, 3'h6);
        ck("reset", 18'h00000, {rd_base, rd_len[4:0], rd_accessed});
        rc(16'hC000, 4'h0, 18'h00000, 6'h30);
        t_walk;
        t_down;
        t_keys;
        t_space;
        stop_test;
    end
endmodule // tb
